// ---- rtl/pll_clock_reset_sequencer.sv ----
// digital side of the clock driver: clock outputs and processor reset/lock pin
`timescale 1ns/1ps
`include "pll_seq_defines.svh"

module pll_clock_reset_sequencer
   import pll_seq_pkg::*;
#(
   parameter int HOLD_CYCLES = `HOLD_MAIN_CYCLES,
   parameter int REQ_QUAL = `REQ_QUAL_CYC,
   parameter int CNT_W = 10
) (
   input wire logic i_clk,                      // oscillator-rate clock, 125 MHz
   input wire logic i_nrst,                     // async reset, active low
   input wire logic i_loop_en,                  // high: locked operation, low: test mode
   input wire logic i_pll_lock,                 // lock status from the analog loop
   input wire logic i_rst_req_n,                // reset request, active low
   input wire logic i_rst_lock_i,               // level seen on the reset/lock pin
   output logic o_rst_lock_o,                   // reset/lock pin output value, always low
   output logic o_rst_lock_oe,                  // high while the pin is pulled low
   output logic [`MAIN_OUT_COPIES-1:0] o_main_clock_out, // main clock copies
   output logic o_inverted_clock_out,           // main clock, inverted
   output logic o_double_rate_clock_out,        // twice the main rate
   output logic o_half_rate_clock_out,          // half the main rate
   output logic o_loop_feedback,                // half-rate feedback to phase detector
   output logic o_osc_enable,                   // oscillator enable to analog loop
   output logic o_test_mode,                    // static test mode active
   output logic o_locked,                       // synchronised lock status
   output logic o_reset_hold,                   // sequencer holding the pin low
   output logic o_pin_low,                      // pin seen low, from any driver
   output logic [CNT_W-1:0] o_hold_count        // main cycles counted in the hold
);

   // ============================================================
   // parameter checks
   generate
      if (REQ_QUAL < 1 || REQ_QUAL > 255) begin : g_bad_qual
         $error("request qualification length out of range");
      end
      if (HOLD_CYCLES < 1 || HOLD_CYCLES > (1 << CNT_W)) begin : g_bad_hold
         $error("hold count does not fit the counter width");
      end
   endgenerate

   localparam logic [7:0] QUAL_LAST = 8'(REQ_QUAL - 1);

   // ============================================================
   // declarations
   seq_link_if #(.CNT_W(CNT_W)) lnk ();

   logic loop_en_ff;
   logic lock_meta_ff;
   logic lock_sync_ff;
   logic lock_ok;
   logic [7:0] req_low_cnt_ff;
   logic req_low_ff;
   logic pin_seen_ff;
   seq_state_t state_ff;
   seq_state_t nxt_state;
   logic drive_low_ff;
   logic nxt_drive_low;
   logic clear_ff;
   logic nxt_clear;
   logic dbl_w;
   logic main_w;
   logic inv_w;
   logic half_w;

   // ============================================================
   // test mode select
   // loop enable steers oscillator
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         loop_en_ff <= 1'b0;
      end else begin
         loop_en_ff <= i_loop_en;
      end
   end

   // the oscillator is off in test mode, so the divider stands still
   assign lnk.run = loop_en_ff;

   // ============================================================
   // lock synchroniser; the analog lock flag has no timing to this clock
   // two-stage lock sync
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         lock_meta_ff <= 1'b0;
         lock_sync_ff <= 1'b0;
      end else begin
         lock_meta_ff <= i_pll_lock;
         lock_sync_ff <= lock_meta_ff;
      end
   end

   // with the oscillator disabled there is nothing to be locked
   assign lock_ok = lock_sync_ff && loop_en_ff;

   // ============================================================
   // request qualification
   // shortest request still seen
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         req_low_cnt_ff <= 8'h00;
         req_low_ff <= 1'b0;
      end else if (i_rst_req_n) begin
         req_low_cnt_ff <= 8'h00;
         req_low_ff <= 1'b0;
      end else if (req_low_cnt_ff == QUAL_LAST) begin
         req_low_ff <= 1'b1;
      end else begin
         req_low_cnt_ff <= req_low_cnt_ff + 8'h01;
      end
   end

   // ============================================================
   // pin readback: another driver on the wired line also shows here
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         pin_seen_ff <= 1'b0;
      end else begin
         pin_seen_ff <= ~i_rst_lock_i;
      end
   end

   // ============================================================
   // sequence controller
   always_comb begin
      nxt_state = state_ff;
      nxt_drive_low = 1'b1;
      nxt_clear = 1'b0;
      case (state_ff)
         ST_POWER_UP: begin
            nxt_clear = 1'b1;
            if (!i_rst_req_n) begin
               nxt_state = ST_REQUEST;
            end else begin
               nxt_state = ST_WAIT_LOCK;
            end
         end
         ST_WAIT_LOCK: begin
            nxt_clear = 1'b1;
            if (!i_rst_req_n) begin
               nxt_state = ST_REQUEST;
            end else if (lock_ok) begin
               nxt_state = ST_HOLD;
            end
         end
         ST_HOLD: begin
            if (req_low_ff || !i_rst_req_n) begin
               nxt_state = ST_REQUEST;
               nxt_clear = 1'b1;
            end else if (lnk.hold_done) begin
               nxt_state = ST_RELEASED;
               nxt_drive_low = 1'b0;
            end
         end
         ST_RELEASED: begin
            nxt_drive_low = 1'b0;
            if (!i_rst_req_n) begin
               nxt_state = ST_REQUEST;
               nxt_drive_low = 1'b1;
               nxt_clear = 1'b1;
            // the pin doubles as lock indicator, so a lost lock pulls it low
            end else if (!lock_ok) begin
               nxt_state = ST_WAIT_LOCK;
               nxt_drive_low = 1'b1;
               nxt_clear = 1'b1;
            end
         end
         ST_REQUEST: begin
            nxt_clear = 1'b1;
            if (i_rst_req_n) begin
               nxt_state = ST_HOLD;
               nxt_clear = 1'b0;
            end
         end
         default: begin
            nxt_state = ST_POWER_UP;
            nxt_clear = 1'b1;
         end
      endcase
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         state_ff <= ST_POWER_UP;
      end else begin
         state_ff <= nxt_state;
      end
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         drive_low_ff <= 1'b1;
         clear_ff <= 1'b1;
      end else begin
         drive_low_ff <= nxt_drive_low;
         clear_ff <= nxt_clear;
      end
   end

   assign lnk.hold_clear = clear_ff;

   // ============================================================
   // open-drain reset/lock pin
   // only ever pull low
   assign o_rst_lock_o = 1'b0;
   assign o_rst_lock_oe = drive_low_ff;

   // ============================================================
   // clock generation and hold counting
   // divider runs regardless of reset state
   clock_phase_divider u_div (
      .i_clk(i_clk),
      .i_nrst(i_nrst),
      .lnk(lnk.divider),
      .o_double_rate(dbl_w),
      .o_main(main_w),
      .o_inverted(inv_w),
      .o_half_rate(half_w)
   );

   reset_hold_counter #(
      .HOLD_CYCLES(HOLD_CYCLES),
      .CNT_W(CNT_W)
   ) u_hold (
      .i_clk(i_clk),
      .i_nrst(i_nrst),
      .lnk(lnk.counter)
   );

   assign o_inverted_clock_out = inv_w;
   assign o_double_rate_clock_out = dbl_w;
   assign o_main_clock_out = {`MAIN_OUT_COPIES{main_w}};
   assign o_half_rate_clock_out = half_w;
   assign o_loop_feedback = half_w;

   // ============================================================
   // status
   assign o_osc_enable = loop_en_ff;
   assign o_test_mode = ~loop_en_ff;
   assign o_locked = lock_sync_ff;
   assign o_reset_hold = drive_low_ff;
   assign o_pin_low = pin_seen_ff;
   assign o_hold_count = lnk.hold_count;

endmodule // pll_clock_reset_sequencer

// ---- inc/pll_seq_defines.svh ----
// constants for the clock and reset sequencer
`ifndef PLL_SEQ_DEFINES_SVH
`define PLL_SEQ_DEFINES_SVH

// ============================================================
// clock rate
`define CLK_FREQ_MHZ 125

// ============================================================
// divider layout: 3-bit phase, bit 0 double rate, bit 1 main, bit 2 half
`define PHASE_W 3
`define PHASE_DBL_BIT 0
`define PHASE_MAIN_BIT 1
`define PHASE_HALF_BIT 2
`define MAIN_OUT_COPIES 3

// ============================================================
// reset hold timing
`define HOLD_MAIN_CYCLES 1024
`define REF_PER_HOLD 512
`define REQ_MIN_PULSE_NS 10
// shortest guaranteed request pulse, rounded down, never below one cycle
`define REQ_QUAL_RAW ((`REQ_MIN_PULSE_NS * `CLK_FREQ_MHZ) / 1000)
`define REQ_QUAL_CYC ((`REQ_QUAL_RAW < 1) ? 1 : `REQ_QUAL_RAW)

// ============================================================
// reset values
`define RST_PHASE 3'h0
`define RST_LEVEL 1'b0

`endif

// ---- inc/pll_seq_pkg.sv ----
// types shared by the clock and reset sequencer
package pll_seq_pkg;

   // ============================================================
   // reset/lock sequence states
   typedef enum logic [2:0] {
      ST_POWER_UP  = 3'b000,
      ST_WAIT_LOCK = 3'b001,
      ST_HOLD      = 3'b010,
      ST_RELEASED  = 3'b011,
      ST_REQUEST   = 3'b100
   } seq_state_t;

endpackage

// ---- inc/seq_link_if.sv ----
// links the sequencer controller with its divider and hold counter
`timescale 1ns/1ps
interface seq_link_if #(
   parameter int CNT_W = 10
);
   logic run;                 // oscillator running
   logic tick_main;           // one pulse per main-clock rising edge
   logic hold_clear;          // restart the hold count
   logic hold_done;           // hold count reached its end
   logic [CNT_W-1:0] hold_count;

   modport divider (
      input run,
      output tick_main
   );
   modport counter (
      input tick_main,
      input hold_clear,
      output hold_done,
      output hold_count
   );
   modport ctrl (
      output run,
      output hold_clear,
      input tick_main,
      input hold_done,
      input hold_count
   );
endinterface

// ---- rtl/clock_phase_divider.sv ----
// divider that builds the aligned clock outputs from the oscillator rate
`timescale 1ns/1ps
`include "pll_seq_defines.svh"
module clock_phase_divider
   import pll_seq_pkg::*;
(
   input wire logic i_clk,           // oscillator-rate clock
   input wire logic i_nrst,          // async reset, active low
   seq_link_if.divider lnk,          // run in, main tick out
   output logic o_double_rate,       // twice the main rate
   output logic o_main,              // main clock level
   output logic o_inverted,          // complement of main
   output logic o_half_rate          // half the main rate
);
   logic [`PHASE_W-1:0] phase_ff;
   logic [`PHASE_W-1:0] nxt_phase;
   logic tick_ff;

   // ============================================================
   // phase counter
   // half of main is bit 2
   // counts down so that phase zero, the reset phase, shows every clock low except the inverted one
   assign nxt_phase = lnk.run ? phase_ff - `PHASE_W'(1) : phase_ff;

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         phase_ff <= `RST_PHASE;
      end else begin
         phase_ff <= nxt_phase;
      end
   end

   // ============================================================
   // outputs: double, main and half rise together, and inverted falls, as the phase wraps from zero to seven
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_double_rate <= `RST_LEVEL;
         o_main <= `RST_LEVEL;
         o_inverted <= ~`RST_LEVEL;
         o_half_rate <= `RST_LEVEL;
         tick_ff <= 1'b0;
      end else begin
         o_double_rate <= nxt_phase[`PHASE_DBL_BIT];
         o_main <= nxt_phase[`PHASE_MAIN_BIT];
         o_inverted <= ~nxt_phase[`PHASE_MAIN_BIT];
         o_half_rate <= nxt_phase[`PHASE_HALF_BIT];
         tick_ff <= lnk.run && (nxt_phase[`PHASE_MAIN_BIT:0] == 2'h3);
      end
   end

   assign lnk.tick_main = tick_ff;

endmodule // clock_phase_divider

// ---- rtl/reset_hold_counter.sv ----
// counts main-clock cycles of the reset hold
`timescale 1ns/1ps
`include "pll_seq_defines.svh"
module reset_hold_counter
   import pll_seq_pkg::*;
#(
   parameter int HOLD_CYCLES = `HOLD_MAIN_CYCLES,
   parameter int CNT_W = 10
) (
   input wire logic i_clk,           // oscillator-rate clock
   input wire logic i_nrst,          // async reset, active low
   seq_link_if.counter lnk           // tick and clear in, done out
);
   logic [CNT_W-1:0] count_ff;
   logic done_ff;
   localparam logic [CNT_W-1:0] LAST = CNT_W'(HOLD_CYCLES - 1);

   generate
      if (HOLD_CYCLES < 1 || HOLD_CYCLES > (1 << CNT_W)) begin : g_bad_count
         $error("hold count does not fit the counter width");
      end
   endgenerate

   // ============================================================
   // count main cycles after clear
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         count_ff <= '0;
         done_ff <= 1'b0;
      end else if (lnk.hold_clear) begin
         count_ff <= '0;
         done_ff <= 1'b0;
      end else if (lnk.tick_main && !done_ff) begin
         count_ff <= (count_ff == LAST) ? count_ff : count_ff + CNT_W'(1);
         done_ff <= (count_ff == LAST);
      end
   end

   assign lnk.hold_done = done_ff;
   assign lnk.hold_count = count_ff;

endmodule // reset_hold_counter

// ---- sim/seq_properties.sv ----
// concurrent checks on the sequencer top-level ports
`timescale 1ns/1ps
`include "pll_seq_defines.svh"
module seq_properties #(
   parameter int HOLD_CYCLES = 8,
   parameter int CNT_W = 10
) (
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic i_loop_en,
   input wire logic i_pll_lock,
   input wire logic i_rst_req_n,
   input wire logic i_rst_lock_i,
   input wire logic o_rst_lock_o,
   input wire logic o_rst_lock_oe,
   input wire logic [`MAIN_OUT_COPIES-1:0] o_main_clock_out,
   input wire logic o_inverted_clock_out,
   input wire logic o_double_rate_clock_out,
   input wire logic o_half_rate_clock_out,
   input wire logic o_loop_feedback,
   input wire logic o_osc_enable,
   input wire logic o_test_mode,
   input wire logic o_locked,
   input wire logic o_reset_hold,
   input wire logic o_pin_low,
   input wire logic [CNT_W-1:0] o_hold_count
);
   int hi_cnt_ff;

   // ============================================================
   // cycles since the request returned high with the pin held low
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         hi_cnt_ff <= 0;
      end else if (!i_rst_req_n || !o_rst_lock_oe) begin
         hi_cnt_ff <= 0;
      end else begin
         hi_cnt_ff <= hi_cnt_ff + 1;
      end
   end

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_nrst);

   // ============================================================
   // clock outputs
   a_inv_complement: assert property (o_main_clock_out == {`MAIN_OUT_COPIES{~o_inverted_clock_out}})
      else $error("inverted output is not the complement of main");
   a_main_period: assert property ($rose(o_main_clock_out[0]) ##1 o_osc_enable [*4] |-> $rose(o_main_clock_out[0]))
      else $error("main clock period is not four cycles");
   a_dbl_aligned: assert property ($rose(o_main_clock_out[0]) |-> $rose(o_double_rate_clock_out))
      else $error("double rate edge not aligned with main");
   a_dbl_period: assert property ($rose(o_double_rate_clock_out) ##1 o_osc_enable [*2] |-> $rose(o_double_rate_clock_out))
      else $error("double rate period is not two cycles");
   a_half_period: assert property ($rose(o_half_rate_clock_out) ##1 o_osc_enable [*8] |-> $rose(o_half_rate_clock_out) && o_loop_feedback)
      else $error("half rate feedback period is not eight cycles");
   a_test_frozen: assert property (o_test_mode |=> $stable(o_main_clock_out) && $stable(o_half_rate_clock_out))
      else $error("clocks moved in test mode");

   // ============================================================
   // reset/lock pin
   a_req_pulls_low: assert property (!i_rst_req_n |=> o_rst_lock_oe)
      else $error("reset request did not pull the pin low");
   a_hold_min: assert property ($fell(o_rst_lock_oe) |-> hi_cnt_ff >= 4 * (HOLD_CYCLES - 1))
      else $error("pin released before the hold count");
   a_never_high: assert property (!o_rst_lock_o)
      else $error("reset pin driven high");
endmodule // seq_properties

// ---- sim/reset_source_model.sv ----
// reset source and processor stand-in on the far side of the sequencer
`timescale 1ns/1ps
module reset_source_model (
   input wire logic i_clk,   // sequencer clock
   input wire logic i_main,  // main clock seen by the processor
   input wire logic i_pin,   // resolved reset/lock line
   output logic o_rst_req_n  // reset request, active low
);
   int ticks;

   initial begin
      o_rst_req_n = 1'b1;
      ticks = 0;
   end

   // processor counts the clocks it gets while held in reset
   always @(posedge i_main) begin
      if (!i_pin) begin
         ticks++;
      end
   end

   task automatic set_req(input logic v);
      @(posedge i_clk);
      #1 o_rst_req_n = v;
   endtask

   // pulse kept at 10 ns or more: two cycles minimum
   task automatic pulse(input int n);
      ticks = 0;
      set_req(1'b0);
      repeat ((n < 2) ? 2 : n) @(posedge i_clk);
      #1 o_rst_req_n = 1'b1;
   endtask
endmodule // reset_source_model

// ---- sim/tb.sv ----
// self-checking bench for the clock and reset sequencer
`timescale 1ns/1ps
`include "pll_seq_defines.svh"
`define CHK(name, exp, got) begin n_compared++; if ((got) !== (exp)) begin n_errors++; $display("CHECK FAILED %s expected %0h seen %0h", name, exp, got); end end
module tb;
   localparam int HOLD = 8;
   localparam int LO = 4 * (HOLD - 1);
   localparam int HI = 4 * HOLD + 10;
   logic i_clk, i_nrst, i_loop_en, i_pll_lock, i_rst_req_n;
   logic o_rst_lock_o, o_rst_lock_oe, o_inverted_clock_out, o_double_rate_clock_out;
   logic o_half_rate_clock_out, o_loop_feedback, o_osc_enable, o_test_mode, o_locked;
   logic o_reset_hold, o_pin_low;
   logic [`MAIN_OUT_COPIES-1:0] o_main_clock_out;
   logic [9:0] o_hold_count;
   wire logic pin_line;
   int n_errors = 0;
   int n_compared = 0;
   int cycles = 0;

   // open-drain line with pull-up
   assign pin_line = o_rst_lock_oe ? 1'b0 : 1'b1;

   pll_clock_reset_sequencer #(.HOLD_CYCLES(HOLD)) dut (.i_clk, .i_nrst, .i_loop_en,
      .i_pll_lock, .i_rst_req_n, .i_rst_lock_i(pin_line), .o_rst_lock_o, .o_rst_lock_oe,
      .o_main_clock_out, .o_inverted_clock_out, .o_double_rate_clock_out,
      .o_half_rate_clock_out, .o_loop_feedback, .o_osc_enable, .o_test_mode, .o_locked,
      .o_reset_hold, .o_pin_low, .o_hold_count);
   reset_source_model src (.i_clk, .i_main(o_main_clock_out[0]), .i_pin(pin_line),
      .o_rst_req_n(i_rst_req_n));

   initial begin
      i_clk = 1'b0;
      forever #4 i_clk = ~i_clk;
   end

   task automatic test_done();
      $display("errors %0d compared %0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // ============================================================
   // shared steps
   task automatic tick(input int n);
      repeat (n) @(posedge i_clk);
      #1;
   endtask

   task automatic wait_release(input int lo, input int hi);
      int c;
      c = 0;
      while (o_rst_lock_oe === 1'b1 && c <= hi) begin
         tick(1);
         c++;
      end
      `CHK("release_early", 1'b1, c >= lo)
      `CHK("release_late", 1'b1, c <= hi)
   endtask

   task automatic do_reset(input logic req, input logic lock);
      i_nrst = 1'b0;
      i_pll_lock = lock;
      src.set_req(req);
      tick(16);
      i_nrst = 1'b1;
   endtask

   // ============================================================
   // scenarios
   task automatic t_start_req_high();
      do_reset(1'b1, 1'b0);
      tick(60);
      `CHK("low_until_lock", 1'b1, o_rst_lock_oe)
      i_pll_lock = 1'b1;
      wait_release(LO, HI);
      `CHK("lock_seen", 1'b1, o_locked)
      `CHK("released_level", 1'b1, pin_line)
      `CHK("never_high", 1'b0, o_rst_lock_o)
   endtask

   task automatic t_req_pulse();
      src.pulse(2);
      `CHK("pulled_low", 1'b1, o_rst_lock_oe)
      `CHK("pin_readback", 1'b1, o_pin_low)
      `CHK("hold_flag", 1'b1, o_reset_hold)
      `CHK("count_cleared", 10'h000, o_hold_count)
      wait_release(LO, HI);
      `CHK("clocks_in_reset", 1'b1, src.ticks >= HOLD)
   endtask

   task automatic t_req_restart();
      src.pulse(2);
      tick(20);
      `CHK("still_held", 1'b1, o_rst_lock_oe)
      src.pulse(3);
      wait_release(LO, HI);
   endtask

   task automatic t_clock_ratio();
      int nm, nd, nh, bad;
      logic pm, pd, ph;
      nm = 0;
      nd = 0;
      nh = 0;
      bad = 0;
      src.set_req(1'b0);
      pm = o_main_clock_out[0];
      pd = o_double_rate_clock_out;
      ph = o_half_rate_clock_out;
      repeat (64) begin
         tick(1);
         nm += (o_main_clock_out[0] && !pm);
         nd += (o_double_rate_clock_out && !pd);
         nh += (o_half_rate_clock_out && !ph);
         bad += (o_inverted_clock_out !== ~o_main_clock_out[0]);
         pm = o_main_clock_out[0];
         pd = o_double_rate_clock_out;
         ph = o_half_rate_clock_out;
      end
      `CHK("main_rises_in_reset", 16, nm)
      `CHK("double_rises", 32, nd)
      `CHK("half_rises", 8, nh)
      `CHK("inverse_mismatch", 0, bad)
      `CHK("feedback_is_half", o_half_rate_clock_out, o_loop_feedback)
      src.set_req(1'b1);
      wait_release(LO, HI);
   endtask

   task automatic t_test_mode();
      logic [`MAIN_OUT_COPIES-1:0] m;
      i_loop_en = 1'b0;
      tick(2);
      m = o_main_clock_out;
      tick(20);
      `CHK("frozen_main", m, o_main_clock_out)
      `CHK("test_mode_on", 1'b1, o_test_mode)
      `CHK("osc_off", 1'b0, o_osc_enable)
      i_loop_en = 1'b1;
      wait_release(0, HI + 8);
   endtask

   task automatic t_start_req_low();
      do_reset(1'b0, 1'b1);
      tick(40);
      `CHK("hold_while_req_low", 1'b1, o_rst_lock_oe)
      src.set_req(1'b1);
      wait_release(LO, HI);
   endtask

   // ============================================================
   // main sequence and hang guard
   initial begin
      i_nrst = 1'b0;
      i_loop_en = 1'b1;
      i_pll_lock = 1'b0;
      t_start_req_high();
      t_req_pulse();
      t_req_restart();
      t_clock_ratio();
      t_test_mode();
      t_start_req_low();
      test_done();
   end

   always @(posedge i_clk) begin
      cycles++;
      if (cycles == 5000) begin
         n_errors++;
         test_done();
      end
   end
endmodule // tb

bind pll_clock_reset_sequencer seq_properties #(.HOLD_CYCLES(HOLD_CYCLES), .CNT_W(CNT_W)) props (
   .i_clk, .i_nrst, .i_loop_en, .i_pll_lock, .i_rst_req_n, .i_rst_lock_i, .o_rst_lock_o,
   .o_rst_lock_oe, .o_main_clock_out, .o_inverted_clock_out, .o_double_rate_clock_out,
   .o_half_rate_clock_out, .o_loop_feedback, .o_osc_enable, .o_test_mode, .o_locked,
   .o_reset_hold, .o_pin_low, .o_hold_count);
